/* design/clock_distribution_pkg.sv */
// constants and types shared by the clock distribution block
// assumes one system clock; register offsets are serial-port addresses
package clock_distribution_pkg;

   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] IFACE_MODE_OFFSET = 6'h01;
   localparam logic [ADDR_W-1:0] TX_INTERP_OFFSET  = 6'h13;
   localparam logic [ADDR_W-1:0] CLK_SOURCE_OFFSET = 6'h15;
   localparam logic [ADDR_W-1:0] AUX_SOURCE_OFFSET = 6'h16;

   // values after reset
   localparam logic [DATA_W-1:0] IFACE_MODE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] TX_INTERP_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] CLK_SOURCE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] AUX_SOURCE_RESET = 8'h00;

   // field positions
   localparam int CLK_MODE_LSB      = 5;
   localparam int AUX_EN_BIT        = 2;
   localparam int DATA_INV_BIT      = 1;
   localparam int TX_INV_SAMPLE_BIT = 5;
   localparam int INTERP_LSB        = 0;
   localparam int PLL_BYPASS_BIT    = 7;
   localparam int PLL_VALID_BIT     = 6;
   localparam int ADC_DIV_BIT       = 5;
   localparam int ALT_TIMING_BIT    = 4;
   localparam int DIV5_BIT          = 3;
   localparam int MULT_LSB          = 0;
   localparam int AUX_SRC_BIT       = 5;

   // field codes
   localparam logic [2:0] CLK_MODE_DEFAULT = 3'h0;
   localparam logic [2:0] CLK_MODE_ALT     = 3'h1;
   localparam logic [2:0] CLK_MODE_CLONE   = 3'h2;
   localparam logic [1:0] INTERP_2X        = 2'h1;
   localparam logic [1:0] INTERP_4X        = 2'h2;
   localparam logic [2:0] MULT_MAX_CODE    = 3'h4;
   localparam int         DIV5_FACTOR      = 5;
   localparam int         PLL_PERIOD_W     = 16;

   typedef enum logic [6:0] {
      MODE_1  = 7'h01,
      MODE_2  = 7'h02,
      MODE_4  = 7'h04,
      MODE_5  = 7'h08,
      MODE_7  = 7'h10,
      MODE_8  = 7'h20,
      MODE_10 = 7'h40
   } timing_mode_t;

   typedef struct packed {
      logic [2:0] clk_mode;
      logic       aux_en;
      logic       data_inv;
      logic       tx_inv_sample;
      logic [1:0] interp;
      logic       bypass;
      logic       adc_div;
      logic       alt;
      logic       div5;
      logic [2:0] mult;
      logic       aux_src;
      logic       fd;
      logic       wide;
   } cfg_t;

endpackage

/* design/clock_edge_divider.sv */
// divides a sampled clock level by 1, 2 or 4 on its rising edges
// assumes the source is a level synchronous to clk
`timescale 1ns/1ps
module clock_edge_divider (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic       src,
   input  wire logic [1:0] sel,
   output logic            clk_out
);
   logic       src_q;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       rise;

   assign rise  = src & ~src_q;
   assign cnt_d = rise ? cnt_q + 2'h1 : cnt_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         src_q <= 1'b0;
         cnt_q <= 2'h0;
      end else if (ce) begin
         src_q <= src;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clk_out <= 1'b0;
      end else if (ce) begin
         case (sel)
            2'h0:    clk_out <= src;
            2'h1:    clk_out <= cnt_d[0];
            default: clk_out <= cnt_d[1];
         endcase
      end
   end

   // a fresh divide setting starts from the old output level, so only
   // check once the same setting was already in force on the last edge
   half_rate_a: assert property (@(posedge clk) disable iff (!resetn) // [RL11]
      ce && $past(ce) && rise && sel == 2'h1 && $past(sel) == 2'h1 |=>
         clk_out != $past(clk_out))
      else $error("divide by two missed a source edge");
endmodule

/* design/pll_multiplier.sv */
// digital model of the multiplier: measures the reference period and
// runs an accumulator at mult/period, optionally divided by five
// assumes the reference is a synchronous level, well below clk/2
`timescale 1ns/1ps
module pll_multiplier
   import clock_distribution_pkg::*;
#(
   parameter int PERIOD_W = clock_distribution_pkg::PLL_PERIOD_W
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic       ref_in,
   input  wire logic [2:0] mult_code,
   input  wire logic       div5,
   output logic            pll_out,
   output logic            period_valid
);
   localparam int ACC_W = PERIOD_W + 3;

   initial begin
      if (PERIOD_W < 4 || PERIOD_W > 28)
         $error("pll_multiplier: PERIOD_W out of range");
   end

   logic                ref_q;
   logic [PERIOD_W-1:0] cnt_q;
   logic [PERIOD_W-1:0] period_q;
   logic [ACC_W-1:0]    acc_q;
   logic [ACC_W-1:0]    inc;
   logic [ACC_W-1:0]    thr;
   logic [ACC_W:0]      sum;
   logic                rise;

   assign rise = ref_in & ~ref_q;
   // reserved multiplier codes fall back to 1x
   assign inc  = (mult_code > MULT_MAX_CODE) ? ACC_W'(2)
                 : ACC_W'(2) << mult_code;
   assign thr  = div5 ? ACC_W'(period_q) * ACC_W'(DIV5_FACTOR)
                 : ACC_W'(period_q);
   assign sum  = {1'b0, acc_q} + {1'b0, inc};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ref_q        <= 1'b0;
         cnt_q        <= '1;
         period_q     <= '0;
         period_valid <= 1'b0;
      end else if (ce) begin
         ref_q <= ref_in;
         if (rise) begin
            cnt_q        <= PERIOD_W'(1);
            period_q     <= cnt_q;
            period_valid <= (cnt_q != '1);
         end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + PERIOD_W'(1);
         end
      end
   end

   // output stops low until a full reference period has been seen
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_q   <= '0;
         pll_out <= 1'b0;
      end else if (ce) begin
         if (!period_valid) begin
            acc_q   <= '0;
            pll_out <= 1'b0;
         end else if (inc >= thr) begin
            acc_q   <= '0;
            pll_out <= ~pll_out;
         end else if (sum >= {1'b0, thr}) begin
            acc_q   <= ACC_W'(sum - {1'b0, thr});
            pll_out <= ~pll_out;
         end else begin
            acc_q <= ACC_W'(sum);
         end
      end
   end

   period_meas_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && rise && cnt_q != '1 |=>
         period_q == $past(cnt_q) && period_valid) // [RL7]
      else $error("reference period not captured");
endmodule

/* design/transceiver_clock_distribution.sv */
// clock distribution and interface clock formatter for the transceiver
// assumes reference clocks arrive as levels synchronous to clk and that
// the serial port front end presents single-cycle register writes
//
// Operation
// RL1: clock mode field bits 7:5, reset 000
// RL2: modes 2, 5, 8, 10 only by programming
// RL3: half duplex: sync pin is direction input
// RL4: formatter maps pins from mode, duplex, width
// RL5: half duplex data clock follows direction
// RL6: interleaved modes need 2x or 4x interpolation
// RL7: DAC clock is Tx reference times multiplier
// RL8: parallel Tx clock is DAC over interpolation
// RL9: interleaved Tx clock is twice that rate
// RL10: Rx clock ignores interleaving
// RL11: normal timing: Rx reference, optionally halved
// RL12: alternate timing: PLL output, optionally halved
// RL13: alternate timing bit picks Rx source
// RL14: aux enable gives clock outside full duplex
// RL15: full duplex aux always clocks; enable inverts
// RL16: aux runs at Rx reference or DAC rate
// RL17: invert bit flips data clock pin
// RL18: Tx inverse sample picks latching edge
// RL19: interpolation field sets Tx clock divisor
// RL20: bypass bit routes reference around PLL
// RL21: ADC divide bit halves Rx clock
// RL22: divide-by-five bit on PLL output
// RL23: multiplier field 1x to 16x
// RL24: aux source bit picks reference or PLL
// RL25: settings switch only while clocks low
`timescale 1ns/1ps
module transceiver_clock_distribution
   import clock_distribution_pkg::*;
#(
   parameter int PERIOD_W = clock_distribution_pkg::PLL_PERIOD_W
) (
   input  wire logic                                     clk,
   input  wire logic                                     resetn,
   input  wire logic                                     ce,
   input  wire logic                                     reg_wr_en,
   input  wire logic [clock_distribution_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [clock_distribution_pkg::DATA_W-1:0] reg_wr_data,
   output logic      [clock_distribution_pkg::DATA_W-1:0] reg_rd_data,
   input  wire logic                                     duplex_select,
   input  wire logic                                     bus_width_select,
   input  wire logic                                     rx_reference_clock_in,
   input  wire logic                                     tx_reference_clock_in,
   input  wire logic                                     sync_direction_pin_in,
   output logic                                          sync_direction_pin_out,
   output logic                                          sync_direction_pin_oe,
   output logic                                          auxiliary_clock_pin,
   output logic                                          data_clock_pin,
   output logic                                          dac_update_clk,
   output logic                                          adc_clk,
   output logic                                          tx_sample_strobe
);
   import clock_distribution_pkg::*;

   logic [2:0]   clk_mode_q;
   logic         aux_en_q, data_inv_q, tx_inv_sample_q;
   logic [1:0]   interp_q;
   logic         bypass_q, adc_div_q, alt_q, div5_q, aux_src_q;
   logic [2:0]   mult_q;
   cfg_t         cfg_d, act_q;
   timing_mode_t mode;
   logic         is_fd, interleaved, apply;
   logic         pll_out, pll_valid, dac_src, rx_src, aux_src_clk;
   logic         data_raw, aux_raw, tx_prev_q;
   logic [1:0]   ilog, tx_sel;
   logic [3:0]   div_src;
   logic [1:0]   div_sel [4];
   logic [3:0]   div_out;
   logic         tx_clk, rx_clk, tx_frame, rx_frame;

   function automatic timing_mode_t decode_mode(input cfg_t c);
      if (c.fd)
         return (c.clk_mode == CLK_MODE_ALT) ? MODE_2 : MODE_1;
      else if (c.clk_mode == CLK_MODE_CLONE)
         return MODE_10;
      else if (c.wide)
         return (c.clk_mode == CLK_MODE_ALT) ? MODE_5 : MODE_4;
      else
         return (c.clk_mode == CLK_MODE_ALT) ? MODE_8 : MODE_7;
   endfunction

   // register writes from the serial port
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clk_mode_q      <= IFACE_MODE_RESET[CLK_MODE_LSB +: 3]; // [RL1]
         aux_en_q        <= IFACE_MODE_RESET[AUX_EN_BIT];
         data_inv_q      <= IFACE_MODE_RESET[DATA_INV_BIT];
         tx_inv_sample_q <= TX_INTERP_RESET[TX_INV_SAMPLE_BIT];
         interp_q        <= TX_INTERP_RESET[INTERP_LSB +: 2];
         bypass_q        <= CLK_SOURCE_RESET[PLL_BYPASS_BIT];
         adc_div_q       <= CLK_SOURCE_RESET[ADC_DIV_BIT];
         alt_q           <= CLK_SOURCE_RESET[ALT_TIMING_BIT];
         div5_q          <= CLK_SOURCE_RESET[DIV5_BIT];
         mult_q          <= CLK_SOURCE_RESET[MULT_LSB +: 3];
         aux_src_q       <= AUX_SOURCE_RESET[AUX_SRC_BIT];
      end else if (ce && reg_wr_en) begin
         case (reg_addr)
            IFACE_MODE_OFFSET: begin
               clk_mode_q <= reg_wr_data[CLK_MODE_LSB +: 3]; // [RL1] [RL2]
               aux_en_q   <= reg_wr_data[AUX_EN_BIT];
               data_inv_q <= reg_wr_data[DATA_INV_BIT];
            end
            TX_INTERP_OFFSET: begin
               tx_inv_sample_q <= reg_wr_data[TX_INV_SAMPLE_BIT];
               interp_q        <= reg_wr_data[INTERP_LSB +: 2];
            end
            CLK_SOURCE_OFFSET: begin
               bypass_q  <= reg_wr_data[PLL_BYPASS_BIT];
               adc_div_q <= reg_wr_data[ADC_DIV_BIT];
               alt_q     <= reg_wr_data[ALT_TIMING_BIT];
               div5_q    <= reg_wr_data[DIV5_BIT];
               mult_q    <= reg_wr_data[MULT_LSB +: 3];
            end
            AUX_SOURCE_OFFSET: begin
               aux_src_q <= reg_wr_data[AUX_SRC_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // readback; reserved bits read zero, bit 6 of the source reg is status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rd_data <= 8'h00;
      end else if (ce) begin
         reg_rd_data <= 8'h00;
         case (reg_addr)
            IFACE_MODE_OFFSET: begin
               reg_rd_data[CLK_MODE_LSB +: 3] <= clk_mode_q;
               reg_rd_data[AUX_EN_BIT]        <= aux_en_q;
               reg_rd_data[DATA_INV_BIT]      <= data_inv_q;
            end
            TX_INTERP_OFFSET: begin
               reg_rd_data[TX_INV_SAMPLE_BIT] <= tx_inv_sample_q;
               reg_rd_data[INTERP_LSB +: 2]   <= interp_q;
            end
            CLK_SOURCE_OFFSET: begin
               reg_rd_data[PLL_BYPASS_BIT]  <= bypass_q;
               reg_rd_data[PLL_VALID_BIT]   <= pll_valid;
               reg_rd_data[ADC_DIV_BIT]     <= adc_div_q;
               reg_rd_data[ALT_TIMING_BIT]  <= alt_q;
               reg_rd_data[DIV5_BIT]        <= div5_q;
               reg_rd_data[MULT_LSB +: 3]   <= mult_q;
            end
            AUX_SOURCE_OFFSET: reg_rd_data[AUX_SRC_BIT] <= aux_src_q;
            default: reg_rd_data <= 8'h00;
         endcase
      end
   end

   always_comb begin
      cfg_d = '{clk_mode: clk_mode_q, aux_en: aux_en_q,
                data_inv: data_inv_q, tx_inv_sample: tx_inv_sample_q,
                interp: interp_q, bypass: bypass_q, adc_div: adc_div_q,
                alt: alt_q, div5: div5_q, mult: mult_q,
                aux_src: aux_src_q, fd: duplex_select,
                wide: ~bus_width_select};
   end

   // new settings only while both raw pin clocks sit low, so no runt
   // can reach the data or aux pin; a source stuck high holds off the change
   assign apply = !data_raw && !aux_raw;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         act_q <= '0;
      end else if (ce && apply) begin
         act_q <= cfg_d; // [RL25]
      end
   end

   assign mode  = decode_mode(act_q); // [RL4]
   assign is_fd = (mode == MODE_1) || (mode == MODE_2);
   // only the 24-bit half duplex modes carry parallel Tx data
   assign interleaved = !((mode == MODE_4) || (mode == MODE_5));

   pll_multiplier #(
      .PERIOD_W     (PERIOD_W)
   ) u_pll (
      .clk          (clk),
      .resetn       (resetn),
      .ce           (ce),
      .ref_in       (tx_reference_clock_in),
      .mult_code    (act_q.mult),        // [RL23]
      .div5         (act_q.div5),        // [RL22]
      .pll_out      (pll_out),
      .period_valid (pll_valid)
   );

   assign dac_src     = act_q.bypass ? tx_reference_clock_in : pll_out;
   assign rx_src      = act_q.alt ? dac_src : rx_reference_clock_in;
   assign aux_src_clk = act_q.aux_src ? dac_src : rx_reference_clock_in;

   // interleaving doubles the rate; 1x with interleave is a setup
   // error on the far side and just runs the DAC rate
   always_comb begin
      case (act_q.interp)
         INTERP_2X: ilog = 2'h1;
         INTERP_4X: ilog = 2'h2;
         default:   ilog = 2'h0;
      endcase
      tx_sel = (interleaved && ilog != 2'h0) ? ilog - 2'h1 : ilog;
   end

   // dividers: Tx clock, Rx clock, Tx frame sync, Rx frame sync
   assign div_src    = {rx_clk, tx_clk, rx_src, dac_src};
   assign div_sel[0] = tx_sel;                       // [RL8] [RL9] [RL19]
   assign div_sel[1] = {1'b0, act_q.adc_div};        // [RL10] [RL21]
   assign div_sel[2] = 2'h1;
   assign div_sel[3] = 2'h1;

   generate
      for (genvar i = 0; i < 4; i++) begin : g_div
         clock_edge_divider u_div (
            .clk     (clk),
            .resetn  (resetn),
            .ce      (ce),
            .src     (div_src[i]),
            .sel     (div_sel[i]),
            .clk_out (div_out[i])
         );
      end
   endgenerate

   assign tx_clk   = div_out[0];
   assign rx_clk   = div_out[1];
   assign tx_frame = div_out[2];
   assign rx_frame = div_out[3];

   always_comb begin
      data_raw = tx_clk;
      aux_raw  = 1'b0;
      case (mode)
         MODE_1: aux_raw = rx_reference_clock_in;
         MODE_2: aux_raw = rx_frame;
         MODE_4, MODE_5, MODE_7, MODE_8, MODE_10: begin
            data_raw = sync_direction_pin_in ? tx_clk : rx_clk; // [RL5]
            aux_raw  = act_q.aux_en & aux_src_clk; // [RL14] [RL16] [RL24]
         end
         default: begin
            data_raw = tx_clk;
            aux_raw  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_direction_pin_out <= 1'b0;
         sync_direction_pin_oe  <= 1'b0;
         auxiliary_clock_pin    <= 1'b0;
         data_clock_pin         <= 1'b0;
         dac_update_clk         <= 1'b0;
         adc_clk                <= 1'b0;
      end else if (ce) begin
         sync_direction_pin_out <= is_fd & tx_frame;
         sync_direction_pin_oe  <= is_fd;                        // [RL3]
         auxiliary_clock_pin    <= aux_raw ^ (is_fd & act_q.aux_en); // [RL15]
         data_clock_pin         <= data_raw ^ act_q.data_inv;    // [RL17]
         dac_update_clk         <= dac_src;              // [RL7] [RL20]
         adc_clk                <= rx_clk;              // [RL11] [RL12] [RL13]
      end
   end

   // one-cycle strobe on the edge of the Tx clock that latches data
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_prev_q        <= 1'b0;
         tx_sample_strobe <= 1'b0;
      end else if (ce) begin
         tx_prev_q        <= tx_clk;
         tx_sample_strobe <= act_q.tx_inv_sample ? (tx_prev_q & ~tx_clk)
                             : (tx_clk & ~tx_prev_q); // [RL18]
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence write_source_s;
      ce && reg_wr_en && reg_addr == CLK_SOURCE_OFFSET;
   endsequence

   sequence read_source_s;
      ce && !reg_wr_en && reg_addr == CLK_SOURCE_OFFSET;
   endsequence

   mode_reset_a: assert property ( // [RL1]
      !$past(resetn) |-> clk_mode_q == CLK_MODE_DEFAULT && mode != MODE_2)
      else $error("clock mode not default after reset");

   sync_dir_in_a: assert property ( // [RL3]
      ce && !is_fd |=> !sync_direction_pin_oe)
      else $error("sync pin driven in half duplex");

   aux_off_a: assert property ( // [RL14]
      ce && !is_fd && !act_q.aux_en |=> !auxiliary_clock_pin)
      else $error("aux pin clocks while disabled");

   hd_data_clk_a: assert property ( // [RL5]
      ce && !is_fd && !sync_direction_pin_in |=>
         data_clock_pin == ($past(rx_clk) ^ $past(act_q.data_inv)))
      else $error("receive data clock not on pin");

   safe_switch_a: assert property ( // [RL25]
      act_q != $past(act_q) |-> $past(!data_raw && !aux_raw))
      else $error("settings switched while a clock was high");

   bypass_read_a: assert property ( // [RL20]
      write_source_s ##1 read_source_s |=>
         reg_rd_data[PLL_BYPASS_BIT] == $past(reg_wr_data[PLL_BYPASS_BIT], 2))
      else $error("bypass bit readback wrong");

   tx_edge_a: assert property ( // [RL18]
      tx_sample_strobe && $past(ce) |->
         $past(tx_clk) == !$past(act_q.tx_inv_sample))
      else $error("strobe on wrong Tx clock edge");

   fd_sync_drive_a: assert property ( // [RL4]
      ce && is_fd |=> sync_direction_pin_oe)
      else $error("sync pin not driven in full duplex");

   fd_aux_clock_a: assert property ( // [RL15]
      ce && mode == MODE_1 |=> auxiliary_clock_pin ==
         ($past(rx_reference_clock_in) ^ $past(act_q.aux_en)))
      else $error("full duplex aux pin not the reference clock");

   alt_aux_frame_a: assert property ( // [RL4]
      ce && mode == MODE_2 |=> auxiliary_clock_pin ==
         ($past(rx_frame) ^ $past(act_q.aux_en)))
      else $error("aux pin not Rx frame sync in mode 2");

   hd_tx_clk_a: assert property ( // [RL5]
      ce && !is_fd && sync_direction_pin_in |=>
         data_clock_pin == ($past(tx_clk) ^ $past(act_q.data_inv)))
      else $error("transmit data clock not on pin");

   bypass_dac_a: assert property ( // [RL20]
      ce && act_q.bypass |=>
         dac_update_clk == $past(tx_reference_clock_in))
      else $error("bypass does not route the Tx reference");
endmodule

/* testbench/dsp_partner.sv */
// far-side processor model: owns the direction line in half duplex
// assumes the device enable is high while the device drives the line
`timescale 1ns/1ps
module dsp_partner (
   input  wire logic dev_oe,
   input  wire logic dev_out,
   input  wire logic tx_req,
   output logic      line
);
   // drives only once the device lets go, so no contention
   assign line = dev_oe ? dev_out : tx_req;
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the clock distribution block
// assumes the design package and the partner model compile first
`timescale 1ns/1ps
module tb_top;
   import clock_distribution_pkg::*;
   typedef struct packed {
      logic       fd;
      logic       wide;
      logic       dir;
      logic [7:0] r01;
      logic [7:0] r13;
      logic [7:0] r15;
      logic [7:0] dac;
      logic [7:0] dat;
      logic [7:0] aux;
      logic [7:0] adc;
      logic       oe;
   } row_t;
   logic              clk    = 1'b0;
   logic              resetn = 1'b0;
   logic              wr_en  = 1'b0;
   logic [ADDR_W-1:0] addr   = '0;
   logic [DATA_W-1:0] wdata  = '0;
   logic [DATA_W-1:0] rdata;
   logic              fd     = 1'b1;
   logic              wide   = 1'b0;
   logic              tx_req = 1'b0;
   logic              rx_ref = 1'b0;
   logic              tx_ref = 1'b0;
   logic              so, soe, aux, dat, dac, adc, stb, dir_line;
   logic              clr    = 1'b0;
   logic              ce     = 1'b1;
   logic [5:0]        sig;
   logic [5:0]        hold;
   logic [5:0]        prev   = '0;
   logic [7:0]        cnt[6];
   logic [7:0]        fs_exp;
   int                tc = 0, rc = 0, cyc = 0;
   int                err_count = 0;
   int                total_checks = 0;
   // tx ref period 16 clocks, rx ref period 20: counts over 320 cycles
   // interleaved rows use 2x or 4x interpolation only
   row_t rows[10] = '{
      '{1,0,0,8'h00,8'h01,8'h80,8'd20,8'd20,8'd16,8'd16,1},
      '{1,0,0,8'h00,8'h01,8'h01,8'd40,8'd40,8'd16,8'd16,1},
      '{0,0,1,8'h00,8'h01,8'h80,8'd20,8'd10,8'd0,8'd16,0},
      '{0,0,0,8'h00,8'h01,8'hA0,8'd20,8'd8,8'd0,8'd8,0},
      '{0,1,1,8'h04,8'h02,8'h80,8'd20,8'd10,8'd16,8'd16,0},
      '{0,1,0,8'h00,8'h01,8'h90,8'd20,8'd20,8'd0,8'd20,0},
      '{1,0,0,8'h00,8'h02,8'h0A,8'd16,8'd8,8'd16,8'd16,1},
      '{1,0,0,8'h20,8'h01,8'h80,8'd20,8'd20,8'd8,8'd16,1},
      '{0,0,1,8'h20,8'h02,8'h80,8'd20,8'd5,8'd0,8'd16,0},
      '{0,1,1,8'h42,8'h21,8'h80,8'd20,8'd20,8'd0,8'd16,0}};

   transceiver_clock_distribution #(.PERIOD_W(8)) dut (
      .clk                    (clk),
      .resetn                 (resetn),
      .ce                     (ce),
      .reg_wr_en              (wr_en),
      .reg_addr               (addr),
      .reg_wr_data            (wdata),
      .reg_rd_data            (rdata),
      .duplex_select          (fd),
      .bus_width_select       (wide),
      .rx_reference_clock_in  (rx_ref),
      .tx_reference_clock_in  (tx_ref),
      .sync_direction_pin_in  (dir_line),
      .sync_direction_pin_out (so),
      .sync_direction_pin_oe  (soe),
      .auxiliary_clock_pin    (aux),
      .data_clock_pin         (dat),
      .dac_update_clk         (dac),
      .adc_clk                (adc),
      .tx_sample_strobe       (stb));

   dsp_partner far_end (
      .dev_oe  (soe),
      .dev_out (so),
      .tx_req  (tx_req),
      .line    (dir_line));

   always #20 clk = ~clk;
   assign sig = {so, stb, adc, aux, dat, dac};

   always @(posedge clk) begin
      tc <= (tc == 7) ? 0 : tc + 1;
      rc <= (rc == 9) ? 0 : rc + 1;
      if (tc == 7) tx_ref <= ~tx_ref;
      if (rc == 9) rx_ref <= ~rx_ref;
      prev <= sig;
      for (int i = 0; i < 6; i++) begin
         if (clr) cnt[i] <= 8'h00;
         else cnt[i] <= cnt[i] + {7'h0, sig[i] & ~prev[i]};
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // edge counts may slip by one at the window borders
   function automatic logic [7:0] near(logic [7:0] s, logic [7:0] e);
      return (s + 8'h01 == e || s == e + 8'h01) ? e : s;
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      addr <= a;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic final_report;
      if (err_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(IFACE_MODE_OFFSET);
      check(rdata, IFACE_MODE_RESET);
      rd(TX_INTERP_OFFSET);
      check(rdata, TX_INTERP_RESET);
      rd(CLK_SOURCE_OFFSET);
      check(rdata & 8'hBF, CLK_SOURCE_RESET);
      foreach (rows[i]) begin
         @(posedge clk);
         fd     <= rows[i].fd;
         wide   <= rows[i].wide;
         tx_req <= rows[i].dir;
         wr(IFACE_MODE_OFFSET, rows[i].r01);
         wr(TX_INTERP_OFFSET, rows[i].r13);
         wr(CLK_SOURCE_OFFSET, rows[i].r15);
         rd(IFACE_MODE_OFFSET);
         check(rdata, rows[i].r01);
         rd(CLK_SOURCE_OFFSET);
         check(rdata & 8'hBF, rows[i].r15);
         repeat (200) @(posedge clk);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         repeat (320) @(posedge clk);
         @(negedge clk);
         check(near(cnt[0], rows[i].dac), rows[i].dac);
         check(near(cnt[1], rows[i].dat), rows[i].dat);
         check(near(cnt[2], rows[i].aux), rows[i].aux);
         check(near(cnt[3], rows[i].adc), rows[i].adc);
         check({7'h0, soe}, {7'h0, rows[i].oe});
         // Tx frame sync is the Tx clock halved, only in full duplex
         fs_exp = rows[i].oe ? rows[i].dat >> 1 : 8'h00;
         check(near(cnt[5], fs_exp), fs_exp);
         if (rows[i].fd | rows[i].dir)
            check(near(cnt[4], rows[i].dat), rows[i].dat);
      end
      // unmapped place ignores writes and reads as zero
      wr(6'h3F, 8'hFF);
      rd(6'h3F);
      check(rdata, 8'h00);
      // a low enable freezes every pin while the references run on
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      hold = sig;
      repeat (10) @(posedge clk);
      check({2'h0, sig}, {2'h0, hold});
      ce <= 1'b1;
      // second reset in mid-run clears pins and registers
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({4'h0, dat, aux, dac, adc}, 8'h00);
      @(posedge clk);
      resetn <= 1'b1;
      rd(CLK_SOURCE_OFFSET);
      check(rdata & 8'hBF, CLK_SOURCE_RESET);
      final_report();
   end
endmodule
